// [src/bcfs_top.sv]
// Boost control and fault supervisor: enable, sync, adaptive boost, faults
// Contract
// R01: Operate only while enable is high; serial port and faults idle otherwise.
// R02: Dimming input duty sets brightness unless serial brightness is selected.
// R03: Fault alert pin is open drain, pulled low on faults.
// R04: Host sets brightness and reads faults over serial port.
// R05: Detect external sync clock at start-up, else use internal oscillator.
// R06: Sync input static high enables spread spectrum, low disables it.
// R07: Pick one of eight boost frequencies from the set-resistor code.
// R08: Enforce minimum on and off times per frequency band.
// R09: Current limit turns switch off at once, on next cycle.
// R10: Current limit sets no fault status and no interrupt.
// R11: Adaptive loop watches only configured strings without open or short faults.
// R12: Raise boost target when any watched output is below headroom.
// R13: Otherwise step boost target down until a watched output touches headroom.
// R14: Start-up to initial target near 88 percent, adapt once drivers active.
// R15: Overvoltage low stops switching, sets flag, drivers stay on. Switching stops only in run state; start-up keeps switching.
// R16: Overvoltage high enters recovery and sets its flag.
// R17: Undervoltage longer than 110 ms enters recovery and sets its flag.
// R18: Charge pump on unless supply and pump pins are tied.
// R19: With pump on, report fly capacitor and pump fault; fault interrupts.
// R20: Pump interrupt enable low keeps pump fault off the alert pin.
// R21: Fault status held until host clears it or enable falls.
// R22: Alert low while any enabled fault flag is set.
// R23: Recovery stops switching, then restarts start-up after a delay.
`timescale 1ns/1ps
`default_nettype none
module bcfs_top
    import bcfs_pkg::*;
#(
    parameter int UV_CYCLES = UV_CYC,
    parameter int RECOVER_CYCLES = RECOVER_CYC,
    parameter int SYNC_WIN_CYCLES = SYNC_WIN_CYC,
    parameter int ADAPT_CYCLES = ADAPT_CYC,
    parameter int STRINGS = 6
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Control pins
    input wire logic enable_pin,
    input wire logic dim_pwm_pin,
    input wire logic boost_clock_sync_input,
    // Resistor straps and pump tie detect
    input wire logic [2:0] boost_freq_set_resistor,
    input wire logic [STRINGS-1:0] string_config_resistor,
    input wire logic pump_tied_detect,
    // Analog comparators
    input wire logic switch_current_sense,
    input wire logic [STRINGS-1:0] headroom_low,
    input wire logic [STRINGS-1:0] string_open_short,
    input wire logic ovp_low_cmp,
    input wire logic ovp_high_cmp,
    input wire logic uvp_cmp,
    input wire logic fly_cap_present,
    input wire logic pump_fault_cmp,
    input wire logic boost_ready,
    // Serial port side (decoded bus requests)
    input wire logic host_brightness_sel,
    input wire logic [15:0] host_brightness,
    input wire logic host_clear_faults,
    input wire logic charge_pump_fault_irq_enable,
    // Outputs
    output logic boost_gate,
    output logic [TGT_W-1:0] boost_target,
    output logic drivers_active,
    output logic spread_enable,
    output logic ext_sync_mode,
    output logic [2:0] freq_code,
    output logic charge_pump_enable,
    output logic dim_source_pwm,
    output logic dim_pwm_out,
    output logic [15:0] brightness,
    output logic serial_active,
    output logic fault_alert_o,
    output logic fault_alert_oe,
    output logic boost_overvoltage_low_flag,
    output logic boost_overvoltage_high_flag,
    output logic boost_undervoltage_timeout_flag,
    output logic fly_capacitor_detected_flag,
    output logic charge_pump_fault_flag
);
    // Reset release synchroniser
    logic rst_s1_r, rst_n;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // Two-flop synchronisers for all pin-level inputs
    localparam int NS = 15 + 3 * STRINGS;
    logic [NS-1:0] raw_in, s1_r, s2_r;
    assign raw_in = {enable_pin, dim_pwm_pin, boost_clock_sync_input, switch_current_sense, ovp_low_cmp,
                     ovp_high_cmp, uvp_cmp, fly_cap_present, pump_fault_cmp, boost_ready, boost_freq_set_resistor,
                     pump_tied_detect, host_clear_faults, headroom_low, string_open_short, string_config_resistor};
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= raw_in;
            s2_r <= s1_r;
        end
    end
    logic en_s, pwm_s, sync_s, ilim_s, ovl_s, ovh_s, uvp_s, cap_s, cpf_s, rdy_s, tied_s, clr_s;
    logic [STRINGS-1:0] hr_s, os_s, cfg_s;
    logic [2:0] fset_s, edges_r;
    assign {en_s, pwm_s, sync_s, ilim_s, ovl_s, ovh_s, uvp_s, cap_s, cpf_s, rdy_s, fset_s,
            tied_s, clr_s, hr_s, os_s, cfg_s} = s2_r;

    // Sync edge finder and static level
    logic sync_d_r, en_d_r;
    logic sync_rise, en_fall;
    assign sync_rise = sync_s && !sync_d_r;
    assign en_fall = en_d_r && !en_s; // R21
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_d_r <= 1'b0;
            en_d_r <= 1'b0;
        end else begin
            sync_d_r <= sync_s;
            en_d_r <= en_s;
        end
    end

    // State machine and timers
    bcfs_state_type state_r, state_nxt;
    logic [CNT_W-1:0] tmr_r, uv_cnt_r, idle_cnt_r;
    logic ext_r;
    logic uv_expire, fault_trip, det_done;
    assign uv_expire = state_r == BCFS_RUN && uvp_s && uv_cnt_r >= CNT_W'(UV_CYCLES - 1);
    assign fault_trip = ovh_s || uv_expire; // R16 R17
    assign det_done = tmr_r >= CNT_W'(SYNC_WIN_CYCLES - 1);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BCFS_OFF: if (en_s) state_nxt = BCFS_DETECT;
            BCFS_DETECT: if (det_done) state_nxt = BCFS_STARTUP;
            BCFS_STARTUP: if (rdy_s) state_nxt = BCFS_RUN;
            BCFS_RUN: if (fault_trip) state_nxt = BCFS_RECOVER;
            BCFS_RECOVER: if (tmr_r >= CNT_W'(RECOVER_CYCLES - 1)) state_nxt = BCFS_DETECT; // R23
            default: state_nxt = BCFS_OFF;
        endcase
        if (!en_s) state_nxt = BCFS_OFF; // R01
        else if (state_r != BCFS_OFF && state_r != BCFS_RECOVER && ovh_s) state_nxt = BCFS_RECOVER;
    end

    // State, phase timer and sync clock detection
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= BCFS_OFF;
            tmr_r <= '0;
            edges_r <= '0;
            ext_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            tmr_r <= (state_nxt != state_r) ? '0 : tmr_r + 1'b1;
            if (state_r == BCFS_DETECT && sync_rise && edges_r != 3'h7) edges_r <= edges_r + 1'b1;
            else if (state_r == BCFS_OFF) edges_r <= '0;
            // Several edges in the window mean a clock; else internal oscillator
            if (state_r == BCFS_DETECT && det_done) ext_r <= edges_r >= 3'h2; // R05
            else if (state_r == BCFS_OFF || idle_cnt_r >= CNT_W'(SYNC_WIN_CYCLES)) ext_r <= 1'b0;
        end
    end

    // Undervoltage timer and lost-clock watch
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            uv_cnt_r <= '0;
            idle_cnt_r <= '0;
        end else begin
            uv_cnt_r <= (state_r == BCFS_RUN && uvp_s) ? uv_cnt_r + 1'b1 : '0; // R17
            idle_cnt_r <= (sync_rise || !ext_r) ? '0 : idle_cnt_r + 1'b1;
        end
    end

    // Adaptive boost target
    logic [STRINGS-1:0] watched;
    logic any_low, any_touch, adapt_tick, touch_r;
    logic [CNT_W-1:0] adapt_cnt_r;
    logic [TGT_W-1:0] tgt_r;
    assign watched = cfg_s & ~os_s; // R11
    assign any_low = |(hr_s & watched);
    assign any_touch = touch_r;
    assign adapt_tick = adapt_cnt_r >= CNT_W'(ADAPT_CYCLES - 1);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            adapt_cnt_r <= '0;
            tgt_r <= TGT_INIT;
            touch_r <= 1'b0;
        end else if (state_r != BCFS_RUN) begin
            adapt_cnt_r <= '0;
            tgt_r <= TGT_INIT; // R14
            touch_r <= 1'b0;
        end else begin
            adapt_cnt_r <= adapt_tick ? '0 : adapt_cnt_r + 1'b1;
            if (adapt_tick) begin
                if (any_low) begin
                    touch_r <= 1'b1;
                    if (tgt_r != TGT_MAX) tgt_r <= tgt_r + 1'b1; // R12
                end else if (!any_touch && tgt_r != '0) begin
                    tgt_r <= tgt_r - 1'b1; // R13
                end
            end
        end
    end

    // Fault flags: set wins over clear; cleared by host or enable falling
    logic clr_all, pump_on, ovl_set, ovh_set, uv_set, cpf_set;
    assign clr_all = clr_s || en_fall; // R21
    assign pump_on = !tied_s; // R18
    assign ovl_set = en_s && state_r != BCFS_OFF && ovl_s; // R15
    assign ovh_set = en_s && state_r != BCFS_OFF && ovh_s; // R16
    assign uv_set = uv_expire; // R17
    assign cpf_set = en_s && pump_on && cpf_s; // R19
    logic f_ovl_r, f_ovh_r, f_uv_r, f_cpf_r, f_cap_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            f_ovl_r <= 1'b0;
            f_ovh_r <= 1'b0;
            f_uv_r <= 1'b0;
            f_cpf_r <= 1'b0;
            f_cap_r <= 1'b0;
        end else begin
            f_ovl_r <= ovl_set || (f_ovl_r && !clr_all);
            f_ovh_r <= ovh_set || (f_ovh_r && !clr_all);
            f_uv_r <= uv_set || (f_uv_r && !clr_all);
            f_cpf_r <= cpf_set || (f_cpf_r && !clr_all);
            f_cap_r <= en_s && pump_on && cap_s; // R19
        end
    end

    // Alert: current limit is not a source; pump fault gated by its enable
    logic alert;
    assign alert = en_s && (f_ovl_r || f_ovh_r || f_uv_r || (f_cpf_r && charge_pump_fault_irq_enable)); // R10 R20 R22

    // Switch timer
    bcfs_sw_if swb ();
    assign swb.run = state_r == BCFS_STARTUP || (state_r == BCFS_RUN && !ovl_s); // R15 R23
    assign swb.freq_code = fset_s; // R07
    assign swb.ext_tick = sync_rise;
    assign swb.ext_mode = ext_r;
    assign swb.cur_limit = ilim_s; // R09
    bcfs_switch_timer u_tmr (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sw(swb)
    );

    // Registered outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            boost_gate <= 1'b0;
            boost_target <= TGT_INIT;
            drivers_active <= 1'b0;
            spread_enable <= 1'b0;
            ext_sync_mode <= 1'b0;
            freq_code <= 3'h0;
            charge_pump_enable <= 1'b0;
            dim_source_pwm <= 1'b1;
            dim_pwm_out <= 1'b0;
            brightness <= 16'h0000;
            serial_active <= 1'b0;
            fault_alert_o <= 1'b0;
            fault_alert_oe <= 1'b0;
            boost_overvoltage_low_flag <= 1'b0;
            boost_overvoltage_high_flag <= 1'b0;
            boost_undervoltage_timeout_flag <= 1'b0;
            fly_capacitor_detected_flag <= 1'b0;
            charge_pump_fault_flag <= 1'b0;
        end else begin
            boost_gate <= swb.gate;
            boost_target <= tgt_r;
            drivers_active <= state_r == BCFS_RUN; // R14 R15
            spread_enable <= en_s && !ext_r && sync_s; // R06
            ext_sync_mode <= ext_r;
            freq_code <= fset_s;
            charge_pump_enable <= en_s && pump_on; // R18
            dim_source_pwm <= !host_brightness_sel; // R02
            dim_pwm_out <= en_s && !host_brightness_sel && pwm_s;
            brightness <= host_brightness_sel ? host_brightness : 16'h0000; // R04
            serial_active <= en_s; // R01
            fault_alert_o <= 1'b0;
            fault_alert_oe <= alert; // R03 R22
            boost_overvoltage_low_flag <= f_ovl_r; // R04
            boost_overvoltage_high_flag <= f_ovh_r;
            boost_undervoltage_timeout_flag <= f_uv_r;
            fly_capacitor_detected_flag <= f_cap_r;
            charge_pump_fault_flag <= f_cpf_r;
        end
    end

    property p_uv_trip;
        @(posedge core_clk) disable iff (!rst_n)
        (uv_expire && en_s) |=> (state_r == BCFS_RECOVER && f_uv_r);
    endproperty
    a_uv_trip: assert property (p_uv_trip) else $error("undervoltage timeout not handled"); // R17
    property p_ovh;
        @(posedge core_clk) disable iff (!rst_n)
        ovh_set |=> f_ovh_r ##1 boost_overvoltage_high_flag;
    endproperty
    a_ovh: assert property (p_ovh) else $error("overvoltage high flag missing"); // R16
    property p_ovl_stop;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == BCFS_RUN && ovl_s) |=> !swb.gate;
    endproperty
    a_ovl_stop: assert property (p_ovl_stop) else $error("switching during overvoltage low"); // R15
    property p_off;
        @(posedge core_clk) disable iff (!rst_n)
        !en_s |=> state_r == BCFS_OFF && !serial_active;
    endproperty
    a_off: assert property (p_off) else $error("active while disabled"); // R01
    property p_cp_mask;
        @(posedge core_clk) disable iff (!rst_n)
        (!charge_pump_fault_irq_enable && !f_ovl_r && !f_ovh_r && !f_uv_r) |=> !fault_alert_oe;
    endproperty
    a_cp_mask: assert property (p_cp_mask) else $error("masked pump fault on alert"); // R20
    property p_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (f_ovl_r && !clr_all) |=> f_ovl_r;
    endproperty
    a_hold: assert property (p_hold) else $error("fault flag lost without clear"); // R21
    property p_init_tgt;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == BCFS_STARTUP) |=> tgt_r == TGT_INIT;
    endproperty
    a_init_tgt: assert property (p_init_tgt) else $error("target not at initial level"); // R14
    property p_raise;
        @(posedge core_clk) disable iff (!rst_n)
        (state_r == BCFS_RUN && adapt_tick && any_low && tgt_r != TGT_MAX) |=> tgt_r == $past(tgt_r) + 1'b1;
    endproperty
    a_raise: assert property (p_raise) else $error("target not raised"); // R12
endmodule
`default_nettype wire

// [src/bcfs_pkg.sv]
// Package: constants and types for the boost control and fault supervisor
package bcfs_pkg;
    localparam int CLK_MHZ = 200;
    // Minimum switch times in ns
    localparam int TON_LO_NS = 150;
    localparam int TOFF_LO_NS = 150;
    localparam int TON_HI_NS = 110;
    localparam int TOFF_HI_NS = 40;
    localparam int TON_LO_CYC = (TON_LO_NS * CLK_MHZ + 999) / 1000;
    localparam int TOFF_LO_CYC = (TOFF_LO_NS * CLK_MHZ + 999) / 1000;
    localparam int TON_HI_CYC = (TON_HI_NS * CLK_MHZ + 999) / 1000;
    localparam int TOFF_HI_CYC = (TOFF_HI_NS * CLK_MHZ + 999) / 1000;
    // Switching periods in ns for the eight frequency codes
    localparam int F100_NS = 10000;
    localparam int F200_NS = 5000;
    localparam int F303_NS = 3300;
    localparam int F400_NS = 2500;
    localparam int F500_NS = 2000;
    localparam int F1818_NS = 550;
    localparam int F2000_NS = 500;
    localparam int F2222_NS = 450;
    // Undervoltage timer, 110 ms
    localparam int UV_TIME_MS = 110;
    localparam int UV_CYC = UV_TIME_MS * CLK_MHZ * 1000;
    // Sync detection window and recovery delay
    localparam int SYNC_WIN_CYC = 20000;
    localparam int RECOVER_CYC = 100000;
    // Adaptive loop sampling interval
    localparam int ADAPT_CYC = 1000;
    // Boost target code span and initial 88 % point
    localparam int TGT_W = 8;
    localparam logic [TGT_W-1:0] TGT_MAX = 8'hFF;
    localparam logic [TGT_W-1:0] TGT_INIT = 8'hE0;
    localparam int PER_W = 16;
    localparam int CNT_W = 32;

    typedef enum logic [2:0] {
        BCFS_OFF = 3'b000,
        BCFS_DETECT = 3'b001,
        BCFS_STARTUP = 3'b010,
        BCFS_RUN = 3'b011,
        BCFS_RECOVER = 3'b100
    } bcfs_state_type;

    // Period in cycles of one frequency code
    function automatic logic [PER_W-1:0] bcfs_period(input logic [2:0] code);
        int ns;
        case (code)
            3'h0: ns = F100_NS;
            3'h1: ns = F200_NS;
            3'h2: ns = F303_NS;
            3'h3: ns = F400_NS;
            3'h4: ns = F500_NS;
            3'h5: ns = F1818_NS;
            3'h6: ns = F2000_NS;
            default: ns = F2222_NS;
        endcase
        return PER_W'(ns * CLK_MHZ / 1000);
    endfunction
endpackage

// [src/bcfs_sw_if.sv]
// Interface: switch timing request between supervisor and switch timer
`timescale 1ns/1ps
`default_nettype none
interface bcfs_sw_if;
    logic run;
    logic [2:0] freq_code;
    logic ext_tick;
    logic ext_mode;
    logic cur_limit;
    logic gate;
    modport sup (output run, output freq_code, output ext_tick, output ext_mode, output cur_limit, input gate);
    modport tmr (input run, input freq_code, input ext_tick, input ext_mode, input cur_limit, output gate);
endinterface
`default_nettype wire

// [src/bcfs_switch_timer.sv]
// Switch timer: boost gate with period, current limit and minimum on/off times
`timescale 1ns/1ps
`default_nettype none
module bcfs_switch_timer
    import bcfs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Request side
    bcfs_sw_if.tmr sw
);
    logic [PER_W-1:0] cnt_r;
    logic gate_r;
    logic [PER_W-1:0] off_cnt_r;
    logic [PER_W-1:0] period;
    logic hi_band;
    logic [PER_W-1:0] min_on;
    logic [PER_W-1:0] min_off;
    logic cycle_start;
    logic want_off;

    assign period = bcfs_period(sw.freq_code);
    assign hi_band = sw.freq_code >= 3'h5;
    assign min_on = hi_band ? PER_W'(TON_HI_CYC) : PER_W'(TON_LO_CYC);
    assign min_off = hi_band ? PER_W'(TOFF_HI_CYC) : PER_W'(TOFF_LO_CYC);
    // External clock sets the cycle start in sync mode
    assign cycle_start = sw.ext_mode ? sw.ext_tick : (cnt_r >= period - 1'b1);
    // Turn off at half period or at once on current limit, but not before min on-time
    assign want_off = (sw.cur_limit || cnt_r >= (period >> 1)) && cnt_r >= min_on;
    assign sw.gate = gate_r;

    // Cycle counter; restarts while the gate is still on or once the minimum off-time has passed
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            gate_r <= 1'b0;
        end else if (!sw.run) begin
            cnt_r <= '0;
            gate_r <= 1'b0;
        end else if (cycle_start && (gate_r || off_cnt_r >= min_off)) begin
            cnt_r <= '0;
            gate_r <= 1'b1; // R09
        end else begin
            cnt_r <= (cnt_r == '1) ? cnt_r : cnt_r + 1'b1;
            if (gate_r && want_off) begin
                gate_r <= 1'b0; // R08 R09
            end
        end
    end

    // Off time since the gate fell; a sync edge must not cut the off phase short
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            off_cnt_r <= '0;
        end else begin
            if (gate_r) off_cnt_r <= '0;
            else if (off_cnt_r != '1) off_cnt_r <= off_cnt_r + 1'b1; // R08
        end
    end

    property p_min_on;
        @(posedge core_clk) disable iff (!rst_n)
        (gate_r && sw.run && cnt_r < min_on) |=> gate_r;
    endproperty
    a_min_on: assert property (p_min_on) else $error("gate on shorter than minimum"); // R08
    property p_min_off;
        @(posedge core_clk) disable iff (!rst_n)
        (!gate_r && sw.run && off_cnt_r < min_off) |=> !gate_r;
    endproperty
    a_min_off: assert property (p_min_off) else $error("gate off shorter than minimum"); // R08
    property p_climit_off;
        @(posedge core_clk) disable iff (!rst_n)
        (gate_r && sw.run && sw.cur_limit && cnt_r >= min_on && !cycle_start) |=> !gate_r;
    endproperty
    a_climit_off: assert property (p_climit_off) else $error("gate not cut on current limit"); // R09
    property p_idle_off;
        @(posedge core_clk) disable iff (!rst_n)
        !sw.run |=> !gate_r;
    endproperty
    a_idle_off: assert property (p_idle_off) else $error("gate active while stopped"); // R15
endmodule
`default_nettype wire

// [test/bcfs_host_model.sv]
// Partner model: host side of the sync pin and the pulled-up alert wire
`timescale 1ns/1ps
`default_nettype none
module bcfs_host_model (
    // Sync pin control
    input wire logic clk_run,
    input wire logic static_level,
    output logic sync_pin,
    // Open-drain alert wire
    input wire logic alert_o,
    input wire logic alert_oe,
    output wire logic alert_line
);
    logic osc = 1'b0;
    // 80 ns clock, phase unrelated to the core clock
    initial begin
        #3.7;
        forever #40 osc = ~osc;
    end
    // Static level between bursts, so no stray edges reach the detector
    assign sync_pin = clk_run ? osc : static_level;
    // Pull-up wins unless the device pulls low; host reads faults here
    assign alert_line = alert_oe ? alert_o : 1'b1;
endmodule
`default_nettype wire

// [test/bcfs_top_tb.sv]
// Testbench: boost control and fault supervisor with its host model
`timescale 1ns/1ps
`default_nettype none
module bcfs_top_tb;
    import bcfs_pkg::*;
    typedef struct {logic [2:0] c; logic l; int ns;} bcfs_row_type;
    // Strap code, sync level, expected period in ns
    bcfs_row_type rows[8] = '{'{3'h0, 1'b0, F100_NS}, '{3'h1, 1'b1, F200_NS}, '{3'h2, 1'b0, F303_NS},
        '{3'h3, 1'b1, F400_NS}, '{3'h4, 1'b0, F500_NS}, '{3'h5, 1'b1, F1818_NS},
        '{3'h6, 1'b0, F2000_NS}, '{3'h7, 1'b1, F2222_NS}};
    int mins[2] = '{TON_LO_CYC, TON_HI_CYC};
    int mismatches = 0;
    int total_checks = 0;
    int n;
    logic [TGT_W-1:0] tg;
    logic core_clk = 0, resetn = 0, en = 0, dim = 0, srun = 0, slvl = 0, tied = 0, cs = 0, rdy = 0;
    logic olo = 0, ohi = 0, uvp = 0, fly = 0, pf = 0, hsel = 0, hclr = 0, irqen = 0;
    logic [2:0] fset = 3'h3;
    logic [5:0] scfg = 6'h3F, hl = 6'h00, sos = 6'h00;
    logic [15:0] hb = 16'h0000;
    wire sync, aline;
    logic gate, dact, spr, ext, cpen, dsrc, dout, ser, ao, aoe, fl, fh, fu, ffly, fcp;
    logic [TGT_W-1:0] tgt;
    logic [2:0] fc;
    logic [15:0] br;
    // Short timer values keep the run brief
    bcfs_top #(.UV_CYCLES(200), .RECOVER_CYCLES(50), .SYNC_WIN_CYCLES(100), .ADAPT_CYCLES(10)) DUT (
        .core_clk(core_clk), .resetn(resetn), .enable_pin(en), .dim_pwm_pin(dim),
        .boost_clock_sync_input(sync), .boost_freq_set_resistor(fset), .string_config_resistor(scfg),
        .pump_tied_detect(tied), .switch_current_sense(cs), .headroom_low(hl), .string_open_short(sos),
        .ovp_low_cmp(olo), .ovp_high_cmp(ohi), .uvp_cmp(uvp), .fly_cap_present(fly),
        .pump_fault_cmp(pf), .boost_ready(rdy), .host_brightness_sel(hsel), .host_brightness(hb),
        .host_clear_faults(hclr), .charge_pump_fault_irq_enable(irqen), .boost_gate(gate),
        .boost_target(tgt), .drivers_active(dact), .spread_enable(spr), .ext_sync_mode(ext),
        .freq_code(fc), .charge_pump_enable(cpen), .dim_source_pwm(dsrc), .dim_pwm_out(dout),
        .brightness(br), .serial_active(ser), .fault_alert_o(ao), .fault_alert_oe(aoe),
        .boost_overvoltage_low_flag(fl), .boost_overvoltage_high_flag(fh),
        .boost_undervoltage_timeout_flag(fu), .fly_capacitor_detected_flag(ffly),
        .charge_pump_fault_flag(fcp));
    bcfs_host_model host (.clk_run(srun), .static_level(slvl), .sync_pin(sync), .alert_o(ao),
        .alert_oe(aoe), .alert_line(aline));
    // 200 MHz core clock
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    // Inputs move 1 ns after the edge
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input bit ok, input string m);
        total_checks++;
        if (!ok) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Cycles up to the next gate rise; a lost gate ends the run
    task automatic rise(output int k);
        logic p;
        k = 1;
        p = gate;
        cyc(1);
        while (!(p === 1'b0 && gate === 1'b1) && k < 5000) begin
            p = gate;
            cyc(1);
            k++;
        end
        if (k >= 5000) begin
            chk(1'b0, "gate never rose");
            wrap_up();
        end
    endtask
    // Gate rises seen over a window
    task automatic nrise(input int w, output int c);
        logic p;
        c = 0;
        repeat (w) begin
            p = gate;
            cyc(1);
            c += (p === 1'b0 && gate === 1'b1);
        end
    endtask
    task automatic power(input logic [2:0] c, input logic l);
        en = 1'b0;
        cyc(6);
        fset = c;
        slvl = l;
        en = 1'b1;
        cyc(220);
    endtask
    initial begin
        cyc(20);
        resetn = 1'b1;
        cyc(4);
        chk(tgt === TGT_INIT && dsrc === 1'b1 && aoe === 1'b0 && ser === 1'b0, "reset values");
        power(3'h3, 1'b0);
        chk(dact === 1'b0 && tgt === TGT_INIT && ser === 1'b1, "drivers before start-up done");
        rdy = 1'b1;
        foreach (rows[i]) begin
            power(rows[i].c, rows[i].l);
            chk(fc === rows[i].c && spr === rows[i].l && ext === 1'b0, "strap or sync mode");
            rise(n);
            rise(n);
            chk(n == rows[i].ns * CLK_MHZ / 1000, "switching period");
        end
        // Current limit held high: gate cut at its minimum on time
        cs = 1'b1;
        foreach (mins[k]) begin
            power(k ? 3'h5 : 3'h3, 1'b0);
            rise(n);
            n = 0;
            while (gate === 1'b1 && n < 5000) begin
                cyc(1);
                n++;
            end
            chk(n >= mins[k] && n <= mins[k] + 3, "on time under current limit");
            chk({fl, fh, fu, fcp} === 4'h0 && aoe === 1'b0, "current limit raised a fault");
        end
        cs = 1'b0;
        power(3'h3, 1'b0);
        olo = 1'b1;
        cyc(20);
        nrise(1200, n);
        chk(fl === 1'b1 && dact === 1'b1 && n == 0, "overvoltage low");
        olo = 1'b0;
        nrise(1200, n);
        chk(n > 0 && fl === 1'b1 && aline === 1'b0, "resume, flag held, alert low");
        hclr = 1'b1;
        cyc(4);
        hclr = 1'b0;
        cyc(8);
        chk(fl === 1'b0 && aline === 1'b1, "host clear");
        ohi = 1'b1;
        cyc(10);
        nrise(40, n);
        chk(fh === 1'b1 && n == 0, "overvoltage high recovery");
        ohi = 1'b0;
        nrise(1500, n);
        chk(n > 0 && fh === 1'b1, "restart after recovery");
        en = 1'b0;
        cyc(8);
        chk(fh === 1'b0 && ser === 1'b0, "enable fall clears");
        // A short dip restarts the undervoltage timer
        power(3'h3, 1'b0);
        uvp = 1'b1;
        cyc(150);
        uvp = 1'b0;
        cyc(5);
        uvp = 1'b1;
        cyc(150);
        chk(fu === 1'b0, "undervoltage flag early");
        cyc(100);
        chk(fu === 1'b1, "undervoltage timeout");
        uvp = 1'b0;
        tied = 1'b1;
        power(3'h3, 1'b0);
        chk(cpen === 1'b0, "pump on while tied");
        tied = 1'b0;
        power(3'h3, 1'b0);
        fly = 1'b1;
        pf = 1'b1;
        cyc(10);
        chk(cpen === 1'b1 && ffly === 1'b1 && fcp === 1'b1 && aoe === 1'b0, "pump flags, masked");
        irqen = 1'b1;
        cyc(6);
        chk(aline === 1'b0, "pump fault alert");
        pf = 1'b0;
        srun = 1'b1;
        power(3'h3, 1'b1);
        chk(ext === 1'b1 && spr === 1'b0, "external sync");
        srun = 1'b0;
        cyc(300);
        chk(ext === 1'b0 && spr === 1'b1, "sync lost, spread from level");
        // Only configured, healthy strings steer the target
        scfg = 6'h0F;
        hl = 6'h20;
        power(3'h3, 1'b0);
        chk(tgt < TGT_INIT, "target steps down");
        hl = 6'h21;
        tg = tgt;
        cyc(100);
        chk(tgt > tg, "target steps up");
        sos = 6'h01;
        cyc(20);
        tg = tgt;
        cyc(100);
        chk(tgt === tg, "faulted string still steering");
        dim = 1'b1;
        cyc(8);
        chk(dout === 1'b1 && dsrc === 1'b1, "dimming input");
        hsel = 1'b1;
        hb = 16'hA5C3;
        cyc(8);
        chk(br === 16'hA5C3 && dsrc === 1'b0, "host brightness");
        wrap_up();
    end
endmodule
`default_nettype wire
